// >>> ere_pkg.sv
package ere_pkg;

    // ****************************************************************
    // record codes
    // ****************************************************************

    // message cause byte codes
    localparam logic [2:0] CAUSE_SPONTANEOUS = 3'h0;
    localparam logic [2:0] CAUSE_INTERMEDIATE = 3'h1;
    localparam logic [2:0] CAUSE_CONTROL_ISSUED = 3'h2;
    localparam logic [2:0] CAUSE_CONTROL_ABORT = 3'h3;
    localparam logic [2:0] CAUSE_CONTROL_REJECTED = 3'h4;
    localparam logic [2:0] CAUSE_FEEDBACK_NEGATIVE = 3'h5;
    localparam logic [2:0] CAUSE_FEEDBACK_POSITIVE = 3'h6;
    localparam logic [2:0] CAUSE_TAG_POSITIVE = CAUSE_CONTROL_ISSUED;
    localparam logic [2:0] CAUSE_TAG_NEGATIVE = CAUSE_CONTROL_REJECTED;

    // information type, low nibble of the indication-type byte
    localparam logic [3:0] ITYPE_SINGLE = 4'h1;
    localparam logic [3:0] ITYPE_DOUBLE = 4'h2;
    localparam logic [3:0] ITYPE_TAP = 4'h3;
    localparam logic [3:0] ITYPE_STAT = 4'h4;

    // indication-type byte flag positions
    localparam int ITYPE_SCAN_BIT = 7;
    localparam int ITYPE_LAST_BIT = 6;

    // register type byte
    localparam logic [7:0] RTYPE_COIL = 8'h00;
    localparam logic [7:0] RTYPE_INPUT = 8'h01;
    localparam logic [7:0] RTYPE_HOLDING = 8'h04;
    localparam logic [7:0] RTYPE_NONE = 8'hFF;

    // value field codes
    localparam logic [5:0] TAP_MAX = 6'h3E;
    localparam logic [15:0] VAL_TAP_INVALID = 16'h003F;
    localparam logic [15:0] VAL_TAP_UNROUTED = 16'h0080;
    localparam logic [15:0] VAL_STAT_BAD = 16'h8000;

    // clock status flags
    localparam logic [7:0] CLK_DST = 8'h10;
    localparam logic [7:0] CLK_FAIL = 8'h20;
    localparam logic [7:0] CLK_INVALID = 8'h40;

    // record, buffer and object index sizes
    localparam int REC_BYTES = 16;
    localparam int REC_W = 8 * REC_BYTES;
    localparam int FIFO_DEPTH = 16;
    localparam int OBJ_IDX_W = 10;

    // ****************************************************************
    // carriers
    // ****************************************************************

    // one annunciation as delivered by the relay data objects
    typedef struct packed {
        logic [7:0] rtype;
        logic [3:0] bit_off;
        logic [16:0] reg_num;
        logic [2:0] cause;
        logic [3:0] itype;
        logic [15:0] value;
        logic bad;
        logic unrouted;
    } ere_obj_s;

    // time stamp of a change
    typedef struct packed {
        logic [15:0] msec;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] month;
        logic [7:0] day;
        logic dst;
        logic fail;
        logic invalid;
        logic [7:0] year;
    } ere_time_s;

endpackage

// >>> ere_fifo.sv
`timescale 1ns/1ps
module ere_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // honest full and empty from the word count
    assign in_ready_o = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem_r[rd_ptr_r];

    // storage, written only on accepted words
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // pointers and occupancy
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            if (pop) rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            if (push && !pop) count_r <= count_r + 1'b1;
            else if (pop && !push) count_r <= count_r - 1'b1;
        end
    end

endmodule

// >>> ere_pack.sv
`timescale 1ns/1ps
module ere_pack (
    // source annunciation and stamp
    input wire ere_pkg::ere_obj_s obj_i,
    input wire ere_pkg::ere_time_s stamp_i,
    // record options
    input wire logic cause_en_i,
    input wire logic scan_i,
    input wire logic last_i,
    // packed record and filter verdict
    output logic [ere_pkg::REC_W-1:0] rec_o,
    output logic keep_o
);

    // ****************************************************************
    // field encoding
    // ****************************************************************

    // identification bytes
    wire type_ok = (obj_i.itype >= ere_pkg::ITYPE_SINGLE) && (obj_i.itype <= ere_pkg::ITYPE_STAT);
    wire rtype_ok = (obj_i.rtype == ere_pkg::RTYPE_COIL) || (obj_i.rtype == ere_pkg::RTYPE_INPUT)
        || (obj_i.rtype == ere_pkg::RTYPE_HOLDING);
    wire [7:0] rtype_b = (type_ok && rtype_ok) ? obj_i.rtype : ere_pkg::RTYPE_NONE;
    wire [7:0] bitoff_b = {4'h0, obj_i.bit_off};
    wire [16:0] addr_full = obj_i.reg_num - 17'h0_0001;
    wire [15:0] addr_w = addr_full[15:0];

    // cause byte and the actual-value filter
    wire actual = (obj_i.cause == ere_pkg::CAUSE_SPONTANEOUS)
        || (obj_i.cause == ere_pkg::CAUSE_INTERMEDIATE)
        || (obj_i.cause == ere_pkg::CAUSE_FEEDBACK_POSITIVE);
    wire [7:0] cause_b = cause_en_i ? {5'h00, obj_i.cause} : 8'h00;
    assign keep_o = cause_en_i || actual;

    // indication type with scan flags, reserved bits forced low
    wire [7:0] itype_b = {scan_i, scan_i && last_i, 2'b00, obj_i.itype};

    // value after the change, per information type
    wire tap_in_range = (obj_i.value[15:6] == 10'h000) && (obj_i.value[5:0] != 6'h00)
        && (obj_i.value[5:0] <= ere_pkg::TAP_MAX);
    wire [15:0] val_single = {15'h0000, obj_i.value[0]};
    wire [15:0] val_double = {14'h0000, obj_i.value[1:0]};
    wire [15:0] val_tap = obj_i.unrouted ? ere_pkg::VAL_TAP_UNROUTED :
        (obj_i.bad || !tap_in_range) ? ere_pkg::VAL_TAP_INVALID : obj_i.value;
    wire [15:0] val_stat = obj_i.bad ? ere_pkg::VAL_STAT_BAD : obj_i.value;
    wire [15:0] value_w = (obj_i.itype == ere_pkg::ITYPE_SINGLE) ? val_single :
        (obj_i.itype == ere_pkg::ITYPE_DOUBLE) ? val_double :
        (obj_i.itype == ere_pkg::ITYPE_TAP) ? val_tap : val_stat;

    // clock status as an or of flags
    wire [7:0] clk_b = (stamp_i.dst ? ere_pkg::CLK_DST : 8'h00)
        | (stamp_i.fail ? ere_pkg::CLK_FAIL : 8'h00)
        | (stamp_i.invalid ? ere_pkg::CLK_INVALID : 8'h00);

    // bytes 1 to 16, byte 1 in the top lane
    assign rec_o = {rtype_b, bitoff_b, addr_w, cause_b, itype_b, value_w,
        stamp_i.msec, stamp_i.hour, stamp_i.minute, stamp_i.month, stamp_i.day,
        clk_b, stamp_i.year};

endmodule

// >>> ere_event_record_encoder.sv
`timescale 1ns/1ps
module ere_event_record_encoder #(
    parameter int OBJ_IDX_W = ere_pkg::OBJ_IDX_W,
    parameter int FIFO_DEPTH = ere_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // configuration
    input wire logic cause_report_en_i,
    input wire logic startup_scan_en_i,
    input wire logic [OBJ_IDX_W-1:0] obj_count_i,
    // event recorder control, scan request bit strobe
    input wire logic scan_request_bit_i,
    output logic scan_busy_o,
    // spontaneous annunciations from the relay objects
    input wire logic ev_valid_i,
    output logic ev_ready_o,
    input wire ere_pkg::ere_obj_s ev_obj_i,
    input wire ere_pkg::ere_time_s ev_time_i,
    // scan fetch port towards the relay objects
    output logic fetch_valid_o,
    output logic [OBJ_IDX_W-1:0] fetch_idx_o,
    input wire logic rsp_valid_i,
    input wire ere_pkg::ere_obj_s rsp_obj_i,
    input wire ere_pkg::ere_time_s now_i,
    // record stream towards the holding register window
    output logic rec_valid_o,
    input wire logic rec_ready_i,
    output logic [ere_pkg::REC_W-1:0] rec_data_o
);

    // ****************************************************************
    // scan sequencer state
    // ****************************************************************

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_PUSH = 4'b1000
    } ere_state_e;

    ere_state_e state_r;
    ere_state_e state_nxt;
    logic boot_chk_r;
    logic scan_pend_r;
    logic [OBJ_IDX_W-1:0] idx_r;
    logic [OBJ_IDX_W-1:0] idx_nxt;
    ere_pkg::ere_obj_s scan_obj_r;
    ere_pkg::ere_time_s stamp_r;

    // fifo handshake and pack outputs
    logic fifo_in_ready;
    logic fifo_in_valid;
    logic [ere_pkg::REC_W-1:0] pack_rec;
    logic pack_keep;

    // ****************************************************************
    // decoding
    // ****************************************************************

    // a scan is due from a request, a boot scan, or a request held pending
    wire boot_start = boot_chk_r && startup_scan_en_i;
    wire scan_due = scan_pend_r || scan_request_bit_i || boot_start;
    wire in_idle = (state_r == ST_IDLE);
    wire count_zero = (obj_count_i == '0);
    wire last_idx = (idx_r == obj_count_i - 1'b1);
    wire scan_push = (state_r == ST_PUSH) && fifo_in_ready;
    wire rsp_take = (state_r == ST_WAIT) && rsp_valid_i;

    // spontaneous events pass only while no scan runs or waits to start
    assign ev_ready_o = in_idle && !scan_due && fifo_in_ready;
    wire ev_take = ev_valid_i && ev_ready_o;

    // source selection for the packer
    wire ere_pkg::ere_obj_s sel_obj = (state_r == ST_PUSH) ? scan_obj_r : ev_obj_i;
    wire ere_pkg::ere_time_s sel_time = (state_r == ST_PUSH) ? stamp_r : ev_time_i;
    wire sel_scan = (state_r == ST_PUSH);

    assign fifo_in_valid = (state_r == ST_PUSH) || (ev_valid_i && ev_ready_o && pack_keep);
    assign scan_busy_o = !in_idle || scan_pend_r;
    assign fetch_valid_o = (state_r == ST_FETCH);
    assign fetch_idx_o = idx_r;

    // ****************************************************************
    // scan sequencer
    // ****************************************************************

    // next state: fetch, wait for response, push, step to next object
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        case (state_r)
            ST_IDLE: begin
                if (scan_due && !count_zero) begin
                    state_nxt = ST_FETCH;
                    idx_nxt = '0;
                end
            end
            ST_FETCH: begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (rsp_valid_i) state_nxt = ST_PUSH;
            end
            ST_PUSH: begin
                if (fifo_in_ready) begin
                    if (last_idx) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_FETCH;
                        idx_nxt = idx_r + 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // state and object index
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            idx_r <= '0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
        end
    end

    // boot check one cycle after reset; pending request set only outside idle, cleared in idle
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            boot_chk_r <= 1'b1;
            scan_pend_r <= 1'b0;
        end else begin
            boot_chk_r <= 1'b0;
            if (scan_request_bit_i && !in_idle) scan_pend_r <= 1'b1;
            else if (in_idle) scan_pend_r <= 1'b0;
        end
    end

    // response capture, stamped with the time it arrived
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            scan_obj_r <= '0;
            stamp_r <= '0;
        end else if (rsp_take) begin
            scan_obj_r <= rsp_obj_i;
            scan_obj_r.cause <= ere_pkg::CAUSE_SPONTANEOUS;
            stamp_r <= now_i;
        end
    end

    // ****************************************************************
    // record packing and buffering
    // ****************************************************************

    // field encoder shared by scan and spontaneous records
    ere_pack u_pack (
        .obj_i(sel_obj),
        .stamp_i(sel_time),
        .cause_en_i(cause_report_en_i),
        .scan_i(sel_scan),
        .last_i(last_idx),
        .rec_o(pack_rec),
        .keep_o(pack_keep)
    );

    // record buffer; a full buffer stalls both sources
    ere_fifo #(
        .WIDTH(ere_pkg::REC_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pack_rec),
        .out_valid_o(rec_valid_o),
        .out_ready_i(rec_ready_i),
        .out_data_o(rec_data_o)
    );

    // ****************************************************************
    // checks
    // ****************************************************************

    // byte views of the record entering the buffer
    wire [7:0] in_rtype = pack_rec[127:120];
    wire [7:0] in_cause = pack_rec[95:88];
    wire [7:0] in_itype = pack_rec[87:80];
    wire [15:0] in_value = pack_rec[79:64];
    wire [7:0] in_clk = pack_rec[15:8];
    wire fifo_push = fifo_in_valid && fifo_in_ready;

    cause_zero_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && !cause_report_en_i |-> in_cause == 8'h00)
        else $error("cause byte not zero with reporting off");

    cause_filter_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ev_take && !cause_report_en_i && ev_obj_i.cause inside {3'h2, 3'h3, 3'h4, 3'h5}
        |-> !fifo_in_valid)
        else $error("commanded-value event recorded with reporting off");

    scan_flag_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push |-> in_itype[ere_pkg::ITYPE_SCAN_BIT] == (state_r == ST_PUSH))
        else $error("scan flag does not match record source");

    scan_last_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && in_itype[ere_pkg::ITYPE_LAST_BIT]
        |-> in_itype[ere_pkg::ITYPE_SCAN_BIT] && last_idx ##1 state_r == ST_IDLE)
        else $error("end-of-scan flag outside the last scan record");

    reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push |-> in_itype[5:4] == 2'b00)
        else $error("reserved indication-type bits set");

    tap_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && in_itype[3:0] == ere_pkg::ITYPE_TAP
        |-> (in_value >= 16'h0001 && in_value <= 16'h003F) || in_value == 16'h0080)
        else $error("tap value outside its codes");

    stat_bad_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && in_itype[3:0] == ere_pkg::ITYPE_STAT && sel_obj.bad
        |-> in_value == 16'h8000)
        else $error("bad statistic value not replaced");

    clock_status_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push |-> in_clk[3:0] == 4'h0 && !in_clk[7]
        && in_clk[5] == sel_time.fail)
        else $error("clock status byte malformed");

    rtype_valid_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && in_rtype != 8'hFF |-> in_itype[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4})
        else $error("valid register type with unknown information type");

    scan_stamp_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        rsp_take |=> state_r == ST_PUSH && stamp_r == $past(now_i))
        else $error("scan record not stamped at response");

    boot_scan_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        boot_chk_r && startup_scan_en_i && !count_zero |-> ##[1:2] fetch_valid_o)
        else $error("start-up scan did not begin");

    request_scan_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        in_idle && scan_request_bit_i && !count_zero |-> ##1 fetch_valid_o && idx_r == '0)
        else $error("requested scan did not begin at object zero");

    fetch_pulse_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fetch_valid_o |=> !fetch_valid_o)
        else $error("fetch strobe longer than one cycle");

    scan_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        scan_busy_o |-> !ev_ready_o)
        else $error("event accepted while a scan is due or running");

    cause_pass_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && cause_report_en_i && !sel_scan |-> in_cause == {5'h00, ev_obj_i.cause})
        else $error("cause byte differs from event cause");

    scan_cause_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && sel_scan |-> in_cause == 8'h00)
        else $error("scan record cause not spontaneous");

    single_value_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && in_itype[3:0] == ere_pkg::ITYPE_SINGLE |-> in_value[15:1] == 15'h0000)
        else $error("single-point value outside 0 and 1");

    double_value_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push && in_itype[3:0] == ere_pkg::ITYPE_DOUBLE |-> in_value[15:2] == 14'h0000)
        else $error("double-point value outside 0 to 3");

    stamp_copy_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push |-> pack_rec[63:48] == sel_time.msec && pack_rec[7:0] == sel_time.year)
        else $error("time stamp fields not carried into record");

    bit_offset_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push |-> pack_rec[119:116] == 4'h0)
        else $error("bit offset beyond 15");

    reg_addr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        fifo_push |-> pack_rec[111:96] == 16'(sel_obj.reg_num - 17'h0_0001))
        else $error("register address not number minus one");

endmodule

// >>> ere_master_model.sv
`timescale 1ns/1ps
// ****
// record reader on the far side
// ****
module ere_master_model (
    // clock
    input wire logic ref_clk_i,
    // record stream
    input wire logic rec_valid_i,
    output logic rec_ready_o,
    input wire logic [ere_pkg::REC_W-1:0] rec_data_i,
    // pacing: 0 prompt, 1 stopped, 2 every other cycle
    input wire logic [1:0] mode_i
);
    logic [ere_pkg::REC_W-1:0] got[$];
    logic tgl = 1'h0;
    initial rec_ready_o = 1'h0;
    // ready moves only after the falling edge
    always @(negedge ref_clk_i) begin
        tgl <= ~tgl;
        rec_ready_o <= (mode_i == 2'h0) || (mode_i == 2'h2 && tgl);
    end
    // keep each record taken at a handshake edge
    always @(posedge ref_clk_i) begin
        if (rec_valid_i && rec_ready_o) begin
            got.push_back(rec_data_i);
        end
    end
endmodule

// >>> ere_event_record_encoder_tb.sv
`timescale 1ns/1ps
module ere_event_record_encoder_tb;
    // ****
    // stimulus and wiring
    // ****
    logic ref_clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic cause_report_en_i = 1'h1;
    logic startup_scan_en_i = 1'h0;
    logic [9:0] obj_count_i = 10'h000;
    logic scan_request_bit_i = 1'h0;
    logic ev_valid_i = 1'h0;
    logic rsp_valid_i = 1'h0;
    ere_pkg::ere_obj_s ev_obj_i = '0;
    ere_pkg::ere_obj_s rsp_obj_i = '0;
    ere_pkg::ere_time_s ev_time_i = '0;
    ere_pkg::ere_time_s now_i = '0;
    ere_pkg::ere_time_s tm = '{16'hea5f, 8'h17, 8'h3b, 8'h0c, 8'h1f, 1'h1, 1'h1, 1'h0, 8'h7c};
    logic scan_busy_o, ev_ready_o, fetch_valid_o, rec_valid_o, rec_ready_i;
    logic [9:0] fetch_idx_o;
    logic [127:0] rec_data_o;
    logic [127:0] exp_q[$];
    logic [1:0] mode = 2'h0;
    int mismatches = 0;
    int n_checks = 0;
    int n_fetch = 0;
    ere_event_record_encoder dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .cause_report_en_i(cause_report_en_i), .startup_scan_en_i(startup_scan_en_i),
        .obj_count_i(obj_count_i), .scan_request_bit_i(scan_request_bit_i),
        .scan_busy_o(scan_busy_o), .ev_valid_i(ev_valid_i), .ev_ready_o(ev_ready_o),
        .ev_obj_i(ev_obj_i), .ev_time_i(ev_time_i), .fetch_valid_o(fetch_valid_o),
        .fetch_idx_o(fetch_idx_o), .rsp_valid_i(rsp_valid_i), .rsp_obj_i(rsp_obj_i),
        .now_i(now_i), .rec_valid_o(rec_valid_o), .rec_ready_i(rec_ready_i),
        .rec_data_o(rec_data_o));
    ere_master_model pm (.ref_clk_i(ref_clk_i), .rec_valid_i(rec_valid_o),
        .rec_ready_o(rec_ready_i), .rec_data_i(rec_data_o), .mode_i(mode));
    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // count fetch strobes so a late server never misses one
    always @(negedge ref_clk_i) begin
        if (fetch_valid_o === 1'h1) n_fetch++;
    end
    // ****
    // compares and helpers
    // ****
    task automatic fail(input logic [127:0] g, input logic [127:0] e);
        mismatches++;
        $display("Error %0t: got %h expected %h", $time, g, e);
    endtask
    task automatic chk(input logic [127:0] g, input logic [127:0] e);
        n_checks++;
        if (g !== e) fail(g, e);
    endtask
    task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) fail(128'(g), 128'(e));
    endtask
    // expected record from the field layout
    function automatic logic [127:0] exp_rec(input ere_pkg::ere_obj_s o,
            input ere_pkg::ere_time_s t, input logic sc, input logic la);
        logic [15:0] v;
        logic [7:0] c;
        v = o.value;
        if (o.itype == 4'h2) v = {14'h0, o.value[1:0]};
        if (o.itype == 4'h3) v = o.unrouted ? 16'h0080 :
            (o.bad || o.value == 16'h0 || o.value > 16'h003e) ? 16'h003f : o.value;
        if (o.itype == 4'h4 && o.bad) v = 16'h8000;
        c = (sc || !cause_report_en_i) ? 8'h00 : {5'h00, o.cause};
        return {o.rtype, 4'h0, o.bit_off, 16'(o.reg_num - 17'h1), c, sc, la, 2'h0, o.itype, v,
            t.msec, t.hour, t.minute, t.month, t.day, 1'h0, t.invalid, t.fail, t.dst, 4'h0, t.year};
    endfunction
    // offer one event and hold it until taken
    task automatic ev(input logic [3:0] it, input logic [15:0] v, input logic b,
            input logic u, input logic [2:0] c, input logic keep);
        int n;
        ere_pkg::ere_obj_s o;
        o = '{8'h04, 4'h4, 17'h00081, c, it, v, b, u};
        if (keep) exp_q.push_back(exp_rec(o, tm, 1'h0, 1'h0));
        @(negedge ref_clk_i);
        ev_valid_i = 1'h1;
        ev_obj_i = o;
        ev_time_i = tm;
        n = 0;
        while (ev_ready_o !== 1'h1 && n < 200) begin
            @(negedge ref_clk_i);
            n++;
        end
        @(negedge ref_clk_i);
        ev_valid_i = 1'h0;
    endtask
    // wait for the reader, then compare all records in order
    task automatic drain(input int n);
        int k;
        k = 0;
        while (pm.got.size() < n && k < 600) begin
            @(negedge ref_clk_i);
            k++;
        end
        repeat (6) @(negedge ref_clk_i);
        chk_v(16'(pm.got.size()), 16'(n));
        for (int i = 0; i < n && i < pm.got.size(); i++) chk(pm.got[i], exp_q[i]);
        pm.got.delete();
        exp_q.delete();
    endtask
    // answer each fetch two cycles late, stamp moves on after
    task automatic serve(input int cnt, input int total);
        int k;
        for (int i = 0; i < total; i++) begin
            k = 0;
            while (n_fetch <= i && k < 300) begin
                @(negedge ref_clk_i);
                k++;
            end
            chk_v(16'(fetch_idx_o), 16'(i % cnt));
            repeat (2) @(negedge ref_clk_i);
            rsp_valid_i = 1'h1;
            rsp_obj_i = '{8'h01, 4'hf, 17'h10000, 3'h6, 4'h1, 16'(i % 2), 1'h0, 1'h0};
            now_i = tm;
            now_i.msec = 16'(i + 7);
            exp_q.push_back(exp_rec(rsp_obj_i, now_i, 1'h1, 1'(i % cnt == cnt - 1)));
            @(negedge ref_clk_i);
            rsp_valid_i = 1'h0;
            now_i.msec = 16'hffff;
        end
    endtask
    task automatic pulse_scan();
        @(negedge ref_clk_i);
        scan_request_bit_i = 1'h1;
        @(negedge ref_clk_i);
        scan_request_bit_i = 1'h0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_values();
        ev(4'h1, 16'h0001, 1'h0, 1'h0, 3'h0, 1'h1);
        ev(4'h1, 16'h0000, 1'h0, 1'h0, 3'h1, 1'h1);
        for (int d = 0; d < 4; d++) ev(4'h2, 16'(d), 1'h0, 1'h0, 3'h6, 1'h1);
        ev(4'h3, 16'h0001, 1'h0, 1'h0, 3'h0, 1'h1);
        ev(4'h3, 16'h003e, 1'h0, 1'h0, 3'h0, 1'h1);
        ev(4'h3, 16'h0005, 1'h1, 1'h0, 3'h0, 1'h1);
        ev(4'h3, 16'h0000, 1'h0, 1'h1, 3'h0, 1'h1);
        ev(4'h4, 16'hfffb, 1'h0, 1'h0, 3'h0, 1'h1);
        ev(4'h4, 16'h1234, 1'h1, 1'h0, 3'h0, 1'h1);
        drain(12);
        $display("t_values done");
    endtask
    task automatic t_causes();
        tm.dst = 1'h0;
        tm.invalid = 1'h1;
        for (int c = 0; c < 7; c++) ev(4'h1, 16'h0001, 1'h0, 1'h0, 3'(c), 1'h1);
        drain(7);
        cause_report_en_i = 1'h0;
        for (int c = 0; c < 7; c++) ev(4'h1, 16'h0001, 1'h0, 1'h0, 3'(c), c < 2 || c == 6);
        drain(3);
        cause_report_en_i = 1'h1;
        $display("t_causes done");
    endtask
    task automatic t_fifo();
        mode = 2'h1;
        for (int i = 0; i < 16; i++) ev(4'h4, 16'(i), 1'h0, 1'h0, 3'h0, 1'h1);
        @(negedge ref_clk_i);
        chk_v(16'(ev_ready_o), 16'h0000);
        mode = 2'h2;
        drain(16);
        $display("t_fifo done");
    endtask
    task automatic t_scan();
        obj_count_i = 10'h003;
        mode = 2'h2;
        n_fetch = 0;
        pulse_scan();
        chk_v(16'(scan_busy_o), 16'h0001);
        @(negedge ref_clk_i);
        pulse_scan();
        serve(3, 6);
        drain(6);
        chk_v(16'(scan_busy_o), 16'h0000);
        ev(4'h1, 16'h0001, 1'h0, 1'h0, 3'h0, 1'h1);
        drain(1);
        $display("t_scan done");
    endtask
    task automatic t_boot();
        startup_scan_en_i = 1'h1;
        obj_count_i = 10'h002;
        sys_rst_i = 1'h1;
        n_fetch = 0;
        repeat (12) @(negedge ref_clk_i);
        sys_rst_i = 1'h0;
        serve(2, 2);
        drain(2);
        $display("t_boot done");
    endtask
    initial begin
        repeat (12) @(negedge ref_clk_i);
        sys_rst_i = 1'h0;
        obj_count_i = 10'h004;
        repeat (4) @(negedge ref_clk_i);
        chk_v(16'({scan_busy_o, fetch_valid_o}), 16'h0000);
        t_values();
        t_causes();
        t_fifo();
        t_scan();
        t_boot();
        results();
    end
    // watchdog well past the expected run
    initial begin
        #(50 * 30000);
        mismatches++;
        results();
    end
endmodule
